// >>> design/osd_pkg.sv
// Constants and types for the OS instruction and privilege decoder.
// Assumes one core clock; opcodes arrive right aligned in 16 bits.
package osd_pkg;
    // Execution levels, 0 most privileged
    localparam logic [1:0] LVL_KERNEL = 2'h0;
    localparam logic [1:0] LVL_EXEC = 2'h1;
    localparam logic [1:0] LVL_SUPER = 2'h2;
    localparam logic [1:0] LVL_USER = 2'h3;
    // Opcodes; one-byte opcodes sit in the low byte
    localparam logic [15:0] OPC_ENABLE_XLATE = 16'h300d;
    localparam logic [15:0] OPC_DISABLE_XLATE = 16'h3013;
    localparam logic [15:0] OPC_PROC_CALL = 16'h30ac;
    localparam logic [15:0] OPC_PROC_RETURN = 16'h30c8;
    localparam logic [15:0] OPC_WAIT = 16'h002f;
    localparam logic [15:0] OPC_IRQ_ACK = 16'h302f;
    localparam logic [15:0] OPC_XLATE_MOVE = 16'h000c;
    localparam logic [15:0] OPC_GATE = 16'h3061;
    localparam logic [15:0] OPC_LEVEL_RETURN = 16'h3045;
    // Widths: 32-bit addresses give the 4 Gbyte space
    localparam int ADDR_W = 32;
    localparam int IRQ_ID_W = 8;
    localparam int SYNC_W = 13;
    // Positions in the synchronised input vector
    localparam int EV_RESET = 0;
    localparam int EV_EXC = 1;
    localparam int EV_FULL = 2;
    localparam int EV_QUICK = 3;
    localparam int POS_SEVERE = 4;
    localparam int POS_ID = 5;
    // Values after reset
    localparam logic [1:0] RST_LEVEL = LVL_KERNEL;
    localparam logic RST_XLATE_EN = 1'b0;
    localparam logic [3:0] RST_PEND = 4'h0;

    typedef enum logic [3:0] {
        OP_NONE, OP_ENABLE_XLATE, OP_DISABLE_XLATE, OP_PROC_CALL,
        OP_PROC_RETURN, OP_WAIT, OP_IRQ_ACK, OP_XLATE_MOVE,
        OP_GATE, OP_LEVEL_RETURN
    } osd_op_e;
    typedef enum logic [1:0] {
        ST_IDLE, ST_XLATE_WAIT, ST_HALTED
    } osd_state_e;
    typedef enum logic [2:0] {
        ACT_NONE, ACT_RESET, ACT_EXC, ACT_FULL, ACT_QUICK, ACT_INSTR
    } osd_act_e;
    typedef enum logic [2:0] {
        MS_NONE, MS_RESET, MS_FULL_IRQ, MS_QUICK_IRQ, MS_EXC_SWITCH,
        MS_EXC_GATE, MS_PRIV_FAULT
    } osd_useq_e;
endpackage : osd_pkg

// >>> design/osd_sync.sv
// Three-stage input synchroniser with agreement filter, one per bit.
// Assumes each input bit is a slow level from outside the core clock.
`timescale 1ns/100ps
module osd_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Raw and filtered levels
    input wire logic [osd_pkg::SYNC_W-1:0] raw,
    output logic [osd_pkg::SYNC_W-1:0] filt
);
    logic [osd_pkg::SYNC_W-1:0] s1_r;
    logic [osd_pkg::SYNC_W-1:0] s2_r;
    logic [osd_pkg::SYNC_W-1:0] s3_r;

    genvar i;
    generate
        for (i = 0; i < osd_pkg::SYNC_W; i++) begin : g_bit
            // First stage feeds only the second
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r[i] <= 1'b0;
                    s2_r[i] <= 1'b0;
                    s3_r[i] <= 1'b0;
                    filt[i] <= 1'b0;
                end else begin
                    s1_r[i] <= raw[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i]) begin
                        filt[i] <= s3_r[i];
                    end
                end
            end
        end
    endgenerate
endmodule : osd_sync

// >>> design/osd_op_decode.sv
// Opcode classifier: operation and privilege class.
// Assumes the opcode is stable while the instruction is offered.
`timescale 1ns/100ps
module osd_op_decode (
    // Opcode in
    input wire logic [15:0] opcode,
    // Class out
    output osd_pkg::osd_op_e op,
    output logic privileged
);
    always_comb begin
        op = osd_pkg::OP_NONE;
        privileged = 1'b0;
        case (opcode)
            osd_pkg::OPC_ENABLE_XLATE: begin
                op = osd_pkg::OP_ENABLE_XLATE;
                privileged = 1'b1;
            end
            osd_pkg::OPC_DISABLE_XLATE: begin
                op = osd_pkg::OP_DISABLE_XLATE;
                privileged = 1'b1;
            end
            osd_pkg::OPC_PROC_CALL: begin
                op = osd_pkg::OP_PROC_CALL;
                privileged = 1'b1;
            end
            osd_pkg::OPC_PROC_RETURN: begin
                op = osd_pkg::OP_PROC_RETURN;
                privileged = 1'b1;
            end
            osd_pkg::OPC_WAIT: begin
                op = osd_pkg::OP_WAIT;
                privileged = 1'b1;
            end
            osd_pkg::OPC_IRQ_ACK: begin
                op = osd_pkg::OP_IRQ_ACK;
                privileged = 1'b1;
            end
            osd_pkg::OPC_XLATE_MOVE: begin
                op = osd_pkg::OP_XLATE_MOVE;
                privileged = 1'b1;
            end
            // Gate pair runs at any level
            osd_pkg::OPC_GATE: op = osd_pkg::OP_GATE;
            osd_pkg::OPC_LEVEL_RETURN: op = osd_pkg::OP_LEVEL_RETURN;
            default: op = osd_pkg::OP_NONE;
        endcase
    end
endmodule : osd_op_decode

// >>> design/osd_decoder.sv
// OS instruction decoder with privilege checks, MMU control and
// implicit switches for reset, interrupts and exceptions.
// Assumes the fetch unit holds an instruction until instr_done and
// that the MMU answers a translation request with one done pulse.
`timescale 1ns/100ps
// Behaviour
// - Four execution levels 0 to 3, zero most privileged.
// - Encoding kernel 0, executive 1, supervisor 2, user 3.
// - Privileged OS instructions run only at kernel level.
// - Gate and return-from-gate run at any level.
// - Opcode 300D enables translation, jumps to address in reg zero, virtual only with an MMU present.
// - Opcode 3013 disables translation, jumps to physical address.
// - 30AC switches process explicitly; 30C8 restores interrupted process.
// - Opcode 2F halts fetching until an interrupt, exception or reset arrives.
// - Opcode 302F acknowledges interrupt, writes its id to reg zero.
// - Privileged 0C translates source address, writes physical result.
// - Opcode 3061 transfers control between levels through a gate.
// - 3045 returns from gate; new level never more privileged.
// - Level ordering checked only on return from gate.
// - Reset, some interrupts, some exceptions switch process implicitly.
// - Full interrupt switches process; quick interrupt takes a gate.
// - Every interrupt or exception starts its built-in microsequence.
// - Severe exceptions switch process, milder ones take a gate.
// - 32-bit virtual space; no MMU or disabled means physical.
module osd_decoder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Instruction offer
    input wire logic instr_valid,
    input wire logic [15:0] instr_opcode,
    output logic instr_ready,
    output logic instr_done,
    // Operands
    input wire logic [osd_pkg::ADDR_W-1:0] general_register_zero,
    input wire logic [osd_pkg::ADDR_W-1:0] src_vaddr,
    input wire logic [1:0] gate_level,
    input wire logic [1:0] return_level,
    input wire logic [1:0] restore_level,
    // Asynchronous event pins
    input wire logic proc_reset_req,
    input wire logic exc_req,
    input wire logic exc_severe,
    input wire logic irq_full,
    input wire logic irq_quick,
    input wire logic [osd_pkg::IRQ_ID_W-1:0] irq_id,
    // MMU side
    input wire logic mmu_present,
    input wire logic mmu_xlate_done,
    input wire logic [osd_pkg::ADDR_W-1:0] mmu_paddr,
    output logic mmu_xlate_req,
    output logic [osd_pkg::ADDR_W-1:0] mmu_vaddr,
    output logic xlate_enabled,
    // Control transfer
    output logic jump_valid,
    output logic jump_virtual,
    output logic [osd_pkg::ADDR_W-1:0] jump_addr,
    output logic proc_switch,
    output logic proc_restore,
    output logic gate_xfer,
    output logic fetch_halted,
    output logic useq_start,
    output osd_pkg::osd_useq_e useq_id,
    // Status and results
    output logic [1:0] cur_level,
    output logic priv_fault,
    output logic level_fault,
    output logic general_register_zero_wr_en,
    output logic [osd_pkg::ADDR_W-1:0] general_register_zero_wr_data,
    output logic dst_wr_en,
    output logic [osd_pkg::ADDR_W-1:0] dst_wr_data
);
    logic [osd_pkg::SYNC_W-1:0] filt;
    logic [3:0] ev_q_r;
    logic [3:0] ev_edge;
    logic [3:0] ev_clr;
    logic [3:0] pend_r;
    logic sev_r;
    logic [osd_pkg::IRQ_ID_W-1:0] irq_id_r;
    osd_pkg::osd_op_e op;
    logic privileged;
    osd_pkg::osd_state_e st_r;
    osd_pkg::osd_state_e st_nxt;
    osd_pkg::osd_act_e act;
    logic deny;
    logic level_transfer_return_bad;
    logic fault;
    logic do_op;
    logic ready_r;
    logic done_r, halt_r;
    logic [1:0] level_r;
    logic xlate_en_r;
    logic xreq_r;
    logic [osd_pkg::ADDR_W-1:0] xva_r;
    logic jv_r;
    logic jvirt_r;
    logic [osd_pkg::ADDR_W-1:0] ja_r;
    logic psw_r;
    logic prst_r;
    logic gate_r;
    logic us_r;
    osd_pkg::osd_useq_e usid_r;
    logic pf_r;
    logic lf_r;
    logic g0we_r;
    logic [osd_pkg::ADDR_W-1:0] g0wd_r;
    logic dwe_r;
    logic [osd_pkg::ADDR_W-1:0] dwd_r;

    osd_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .raw({irq_id, exc_severe, irq_quick, irq_full, exc_req,
              proc_reset_req}),
        .filt(filt)
    );

    osd_op_decode u_dec (
        .opcode(instr_opcode),
        .op(op),
        .privileged(privileged)
    );

    // Event edges latch as pending; set beats a same-cycle clear
    assign ev_edge = filt[3:0] & ~ev_q_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ev_q_r <= osd_pkg::RST_PEND;
            pend_r <= osd_pkg::RST_PEND;
        end else begin
            ev_q_r <= filt[3:0];
            pend_r <= ev_edge | (pend_r & ~ev_clr);
        end
    end

    // Id and severity are sampled with their request edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_id_r <= '0;
            sev_r <= 1'b0;
        end else begin
            if (ev_edge[osd_pkg::EV_FULL] || ev_edge[osd_pkg::EV_QUICK]) begin
                irq_id_r <= filt[osd_pkg::SYNC_W-1:osd_pkg::POS_ID];
            end
            if (ev_edge[osd_pkg::EV_EXC]) begin
                sev_r <= filt[osd_pkg::POS_SEVERE];
            end
        end
    end

    // Events outrank instructions; a pending translation finishes first
    always_comb begin
        act = osd_pkg::ACT_NONE;
        if (st_r != osd_pkg::ST_XLATE_WAIT) begin
            if (pend_r[osd_pkg::EV_RESET]) begin
                act = osd_pkg::ACT_RESET;
            end else if (pend_r[osd_pkg::EV_EXC]) begin
                act = osd_pkg::ACT_EXC;
            end else if (pend_r[osd_pkg::EV_FULL]) begin
                act = osd_pkg::ACT_FULL;
            end else if (pend_r[osd_pkg::EV_QUICK]) begin
                act = osd_pkg::ACT_QUICK;
            end else if (st_r == osd_pkg::ST_IDLE && instr_valid &&
                         ready_r) begin
                act = osd_pkg::ACT_INSTR;
            end
        end
    end

    always_comb begin
        ev_clr = 4'h0;
        ev_clr[osd_pkg::EV_RESET] = (act == osd_pkg::ACT_RESET);
        ev_clr[osd_pkg::EV_EXC] = (act == osd_pkg::ACT_EXC);
        ev_clr[osd_pkg::EV_FULL] = (act == osd_pkg::ACT_FULL);
        ev_clr[osd_pkg::EV_QUICK] = (act == osd_pkg::ACT_QUICK);
    end

    assign deny = privileged && level_r != osd_pkg::LVL_KERNEL;
    // Only the gate return checks ordering; gate itself does not
    assign level_transfer_return_bad = op == osd_pkg::OP_LEVEL_RETURN &&
                      return_level < level_r;
    assign fault = act == osd_pkg::ACT_INSTR && (deny || level_transfer_return_bad);
    assign do_op = act == osd_pkg::ACT_INSTR && !deny && !level_transfer_return_bad;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            osd_pkg::ST_IDLE: begin
                if (do_op && op == osd_pkg::OP_WAIT) begin
                    st_nxt = osd_pkg::ST_HALTED;
                end else if (do_op && op == osd_pkg::OP_XLATE_MOVE &&
                             xlate_en_r) begin
                    st_nxt = osd_pkg::ST_XLATE_WAIT;
                end
            end
            osd_pkg::ST_XLATE_WAIT: begin
                if (mmu_xlate_done) begin
                    st_nxt = osd_pkg::ST_IDLE;
                end
            end
            osd_pkg::ST_HALTED: begin
                if (act != osd_pkg::ACT_NONE) begin
                    st_nxt = osd_pkg::ST_IDLE;
                end
            end
            default: st_nxt = osd_pkg::ST_IDLE;
        endcase
    end

    // Ready drops after a take so a held offer runs once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= osd_pkg::ST_IDLE;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            halt_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            halt_r <= st_nxt == osd_pkg::ST_HALTED;
            ready_r <= st_nxt == osd_pkg::ST_IDLE &&
                       act != osd_pkg::ACT_INSTR &&
                       st_r != osd_pkg::ST_XLATE_WAIT;
            done_r <= (act == osd_pkg::ACT_INSTR &&
                       st_nxt != osd_pkg::ST_XLATE_WAIT) ||
                      (st_r == osd_pkg::ST_XLATE_WAIT && mmu_xlate_done);
        end
    end

    // Execution level; handlers are entered at kernel
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= osd_pkg::RST_LEVEL;
        end else if ((act != osd_pkg::ACT_NONE &&
                      act != osd_pkg::ACT_INSTR) || fault) begin
            level_r <= osd_pkg::LVL_KERNEL;
        end else if (do_op) begin
            case (op)
                osd_pkg::OP_PROC_RETURN: level_r <= restore_level;
                osd_pkg::OP_GATE: level_r <= gate_level;
                osd_pkg::OP_LEVEL_RETURN: level_r <= return_level;
                default: level_r <= level_r;
            endcase
        end
    end

    // Translation state; no MMU means physical
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xlate_en_r <= osd_pkg::RST_XLATE_EN;
        end else if (!mmu_present) begin
            xlate_en_r <= 1'b0;
        end else if (do_op && op == osd_pkg::OP_ENABLE_XLATE) begin
            xlate_en_r <= 1'b1;
        end else if (do_op && op == osd_pkg::OP_DISABLE_XLATE) begin
            xlate_en_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            jv_r <= 1'b0;
            jvirt_r <= 1'b0;
            ja_r <= '0;
        end else begin
            jv_r <= do_op && (op == osd_pkg::OP_ENABLE_XLATE ||
                              op == osd_pkg::OP_DISABLE_XLATE);
            if (do_op && op == osd_pkg::OP_ENABLE_XLATE) begin
                ja_r <= general_register_zero;
                jvirt_r <= mmu_present;
            end else if (do_op && op == osd_pkg::OP_DISABLE_XLATE) begin
                ja_r <= general_register_zero;
                jvirt_r <= 1'b0;
            end
        end
    end

    // Address move: through the MMU when on, else physical
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xreq_r <= 1'b0;
            xva_r <= '0;
            dwe_r <= 1'b0;
            dwd_r <= '0;
        end else begin
            xreq_r <= st_nxt == osd_pkg::ST_XLATE_WAIT &&
                      st_r != osd_pkg::ST_XLATE_WAIT;
            dwe_r <= 1'b0;
            if (do_op && op == osd_pkg::OP_XLATE_MOVE) begin
                xva_r <= src_vaddr;
                if (!xlate_en_r) begin
                    dwe_r <= 1'b1;
                    dwd_r <= src_vaddr;
                end
            end else if (st_r == osd_pkg::ST_XLATE_WAIT &&
                         mmu_xlate_done) begin
                dwe_r <= 1'b1;
                dwd_r <= mmu_paddr;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            g0we_r <= 1'b0;
            g0wd_r <= '0;
        end else begin
            g0we_r <= do_op && op == osd_pkg::OP_IRQ_ACK;
            if (do_op && op == osd_pkg::OP_IRQ_ACK) begin
                g0wd_r <= {{(osd_pkg::ADDR_W-osd_pkg::IRQ_ID_W){1'b0}},
                           irq_id_r};
            end
        end
    end

    // Switches, gates and microsequence launch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            psw_r <= 1'b0;
            prst_r <= 1'b0;
            gate_r <= 1'b0;
            pf_r <= 1'b0;
            lf_r <= 1'b0;
        end else begin
            psw_r <= act == osd_pkg::ACT_RESET ||
                     act == osd_pkg::ACT_FULL ||
                     (act == osd_pkg::ACT_EXC && sev_r) ||
                     (do_op && op == osd_pkg::OP_PROC_CALL);
            prst_r <= do_op && op == osd_pkg::OP_PROC_RETURN;
            gate_r <= act == osd_pkg::ACT_QUICK || fault ||
                      (act == osd_pkg::ACT_EXC && !sev_r) ||
                      (do_op && op == osd_pkg::OP_GATE);
            pf_r <= fault && deny;
            lf_r <= fault && !deny;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            us_r <= 1'b0;
            usid_r <= osd_pkg::MS_NONE;
        end else begin
            us_r <= (act != osd_pkg::ACT_NONE &&
                     act != osd_pkg::ACT_INSTR) || fault;
            case (act)
                osd_pkg::ACT_RESET: usid_r <= osd_pkg::MS_RESET;
                osd_pkg::ACT_FULL: usid_r <= osd_pkg::MS_FULL_IRQ;
                osd_pkg::ACT_QUICK: usid_r <= osd_pkg::MS_QUICK_IRQ;
                osd_pkg::ACT_EXC: usid_r <= sev_r ?
                    osd_pkg::MS_EXC_SWITCH : osd_pkg::MS_EXC_GATE;
                osd_pkg::ACT_INSTR: usid_r <= fault ?
                    osd_pkg::MS_PRIV_FAULT : osd_pkg::MS_NONE;
                default: usid_r <= osd_pkg::MS_NONE;
            endcase
        end
    end

    assign instr_ready = ready_r;
    assign instr_done = done_r;
    assign cur_level = level_r;
    assign xlate_enabled = xlate_en_r;
    assign mmu_xlate_req = xreq_r;
    assign mmu_vaddr = xva_r;
    assign jump_valid = jv_r;
    assign jump_virtual = jvirt_r;
    assign jump_addr = ja_r;
    assign proc_switch = psw_r;
    assign proc_restore = prst_r;
    assign gate_xfer = gate_r;
    assign fetch_halted = halt_r;
    assign useq_start = us_r;
    assign useq_id = usid_r;
    assign priv_fault = pf_r;
    assign level_fault = lf_r;
    assign general_register_zero_wr_en = g0we_r;
    assign general_register_zero_wr_data = g0wd_r;
    assign dst_wr_en = dwe_r;
    assign dst_wr_data = dwd_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_instr_take(osd_pkg::osd_op_e o);
        act == osd_pkg::ACT_INSTR && op == o;
    endsequence
    sequence s_kernel_take(osd_pkg::osd_op_e o);
        s_instr_take(o) ##0 level_r == osd_pkg::LVL_KERNEL;
    endsequence

    a_priv_blocked: assert property (
        act == osd_pkg::ACT_INSTR && privileged && level_r != 2'h0
        |=> pf_r && gate_r && level_r == 2'h0 && !jv_r && !g0we_r)
        else $error("privileged op ran outside kernel");
    a_gate_any_level: assert property (
        s_instr_take(osd_pkg::OP_GATE)
        |=> gate_r && !pf_r && level_r == $past(gate_level))
        else $error("gate refused or wrong level");
    a_enable_jump: assert property (
        s_kernel_take(osd_pkg::OP_ENABLE_XLATE) ##0 mmu_present
        |=> xlate_en_r && jv_r && jvirt_r &&
            ja_r == $past(general_register_zero))
        else $error("enable translation jump wrong");
    a_disable_jump: assert property (
        s_kernel_take(osd_pkg::OP_DISABLE_XLATE)
        |=> !xlate_en_r && jv_r && !jvirt_r &&
            ja_r == $past(general_register_zero))
        else $error("disable translation jump wrong");
    a_call_switch: assert property (
        s_kernel_take(osd_pkg::OP_PROC_CALL) |=> psw_r && !prst_r)
        else $error("explicit process call missing");
    a_wait_halts: assert property (
        s_kernel_take(osd_pkg::OP_WAIT) ##1 pend_r == 4'h0 [*2]
        |-> fetch_halted && !ready_r)
        else $error("wait did not hold fetch");
    a_ack_id: assert property (
        s_kernel_take(osd_pkg::OP_IRQ_ACK)
        |=> g0we_r && g0wd_r[7:0] == $past(irq_id_r))
        else $error("acknowledge id not written");
    a_return_order: assert property (
        s_instr_take(osd_pkg::OP_LEVEL_RETURN) ##0 return_level < level_r
        |=> lf_r && level_r == 2'h0 ##1 !lf_r)
        else $error("gate return raised privilege");
    a_full_switch: assert property (
        act == osd_pkg::ACT_FULL
        |=> psw_r && !gate_r && us_r && usid_r == osd_pkg::MS_FULL_IRQ)
        else $error("full interrupt not a switch");
    a_no_mmu_phys: assert property (
        !mmu_present |=> !xlate_en_r)
        else $error("translation on without MMU");
endmodule : osd_decoder

// >>> testbench/osd_mmu_model.sv
// Behavioural MMU: answers each translation request after lat+1 cycles.
// Assumes one request at a time from the decoder.
`timescale 1ns/100ps
module osd_mmu_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Request side
    input wire logic req,
    input wire logic [osd_pkg::ADDR_W-1:0] vaddr,
    input wire logic [3:0] lat,
    // Answer side
    output logic done,
    output logic [osd_pkg::ADDR_W-1:0] paddr
);
    logic busy_r;
    logic [3:0] cnt_r;
    logic [osd_pkg::ADDR_W-1:0] map;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (req) begin
                busy_r <= 1'b1;
                cnt_r <= lat;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                done <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
    // Page bits flipped; inverted outside done so stale data never matches
    assign map = {vaddr[31:12] ^ 20'hfffff, vaddr[11:0]};
    assign paddr = done ? map : ~map;
endmodule : osd_mmu_model

// >>> testbench/os_instruction_privilege_decoder_test.sv
// Self-checking bench for the OS instruction decoder.
// Assumes the MMU model answers translations after a few cycles.
`timescale 1ns/100ps
module os_instruction_privilege_decoder_test;
    logic clk_sys, rst_n, instr_valid, instr_ready, instr_done;
    logic [15:0] instr_opcode;
    logic [31:0] gpr0, src_vaddr, mmu_paddr, mmu_vaddr, jump_addr;
    logic [31:0] gw_d, dst_wr_data;
    logic [1:0] gate_level, return_level, restore_level, cur_level;
    logic [3:0] evp;
    logic exc_severe, mmu_xlate_done, mmu_xlate_req, xlate_enabled;
    logic jump_valid, jump_virtual, proc_switch, proc_restore, gate_xfer;
    logic fetch_halted, useq_start, priv_fault, level_fault, gw_en;
    logic dst_wr_en, mmu_present = 1'b1;
    logic [7:0] irq_id;
    osd_pkg::osd_useq_e useq_id;
    int error_cnt = 0, compares = 0;
    // {opcode, jv, virt, switch, restore, gate, gpr0 write}
    logic [21:0] rows [6] = '{{osd_pkg::OPC_ENABLE_XLATE, 6'h30},
        {osd_pkg::OPC_DISABLE_XLATE, 6'h20}, {osd_pkg::OPC_PROC_CALL, 6'h08},
        {osd_pkg::OPC_PROC_RETURN, 6'h04}, {osd_pkg::OPC_GATE, 6'h02},
        {osd_pkg::OPC_IRQ_ACK, 6'h01}};
    // {pin, severe, switch, microsequence}
    logic [6:0] evt [5] = '{{2'd2, 2'b01, osd_pkg::MS_FULL_IRQ},
        {2'd3, 2'b00, osd_pkg::MS_QUICK_IRQ},
        {2'd1, 2'b11, osd_pkg::MS_EXC_SWITCH},
        {2'd1, 2'b00, osd_pkg::MS_EXC_GATE}, {2'd0, 2'b01, osd_pkg::MS_RESET}};
    osd_decoder u_osd_decoder (.clk_sys(clk_sys), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_opcode(instr_opcode),
        .instr_ready(instr_ready), .instr_done(instr_done),
        .general_register_zero(gpr0), .src_vaddr(src_vaddr),
        .gate_level(gate_level), .return_level(return_level),
        .restore_level(restore_level), .proc_reset_req(evp[0]),
        .exc_req(evp[1]), .exc_severe(exc_severe), .irq_full(evp[2]),
        .irq_quick(evp[3]), .irq_id(irq_id), .mmu_present(mmu_present),
        .mmu_xlate_done(mmu_xlate_done), .mmu_paddr(mmu_paddr),
        .mmu_xlate_req(mmu_xlate_req), .mmu_vaddr(mmu_vaddr),
        .xlate_enabled(xlate_enabled), .jump_valid(jump_valid),
        .jump_virtual(jump_virtual), .jump_addr(jump_addr),
        .proc_switch(proc_switch), .proc_restore(proc_restore),
        .gate_xfer(gate_xfer), .fetch_halted(fetch_halted),
        .useq_start(useq_start), .useq_id(useq_id), .cur_level(cur_level),
        .priv_fault(priv_fault), .level_fault(level_fault),
        .general_register_zero_wr_en(gw_en),
        .general_register_zero_wr_data(gw_d), .dst_wr_en(dst_wr_en),
        .dst_wr_data(dst_wr_data));
    osd_mmu_model u_osd_mmu_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .req(mmu_xlate_req), .vaddr(mmu_vaddr), .lat(4'h3),
        .done(mmu_xlate_done), .paddr(mmu_paddr));
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic run(input logic [15:0] op);
        int n;
        @(posedge clk_sys); #1;
        instr_opcode = op;
        instr_valid = 1'b1;
        n = 0;
        do begin @(posedge clk_sys); #1; n++; end
        while (instr_done !== 1'b1 && n < 50);
        chk({instr_done, instr_ready}, 2'h2);
        instr_valid = 1'b0;
    endtask : run
    task automatic ev(input int i, input logic sev);
        int n;
        exc_severe = sev;
        repeat (6) @(posedge clk_sys); #1;
        evp[i] = 1'b1;
        n = 0;
        do begin @(posedge clk_sys); #1; n++; end
        while (useq_start !== 1'b1 && n < 40);
        evp[i] = 1'b0;
    endtask : ev
    task conclude;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial begin
        {rst_n, instr_valid, instr_opcode, evp, exc_severe} = '0;
        {gate_level, return_level, restore_level, irq_id} = '0;
        gpr0 = 32'h1234_5670;
        src_vaddr = 32'h0001_2345;
        repeat (4) @(posedge clk_sys); #1;
        rst_n = 1'b1;
        chk({cur_level, xlate_enabled}, 3'h0);
        for (int k = 0; k < 6; k++) begin
            run(rows[k][21:6]);
            chk({jump_valid, jump_virtual, proc_switch, proc_restore,
                gate_xfer, gw_en}, rows[k][5:0]);
            chk(jump_addr, gpr0);
            chk(xlate_enabled, k == 0);
        end
        $display("table test done");
        run(osd_pkg::OPC_ENABLE_XLATE);
        run(osd_pkg::OPC_XLATE_MOVE);
        chk(dst_wr_data, src_vaddr ^ 32'hffff_f000);
        mmu_present = 1'b0;
        run(osd_pkg::OPC_ENABLE_XLATE);
        chk({jump_valid, jump_virtual}, 2'h2);
        run(osd_pkg::OPC_XLATE_MOVE);
        chk({dst_wr_en, dst_wr_data}, {1'b1, src_vaddr});
        $display("translate test done");
        gate_level = 2'h3;
        run(osd_pkg::OPC_GATE);
        chk(cur_level, 2'h3);
        run(osd_pkg::OPC_ENABLE_XLATE);
        chk({priv_fault, jump_valid, cur_level}, 4'h8);
        gate_level = 2'h2;
        run(osd_pkg::OPC_GATE);
        return_level = 2'h1;
        run(osd_pkg::OPC_LEVEL_RETURN);
        chk(level_fault, 1'b1);
        return_level = 2'h3;
        run(osd_pkg::OPC_LEVEL_RETURN);
        chk({level_fault, cur_level}, 3'h3);
        gate_level = 2'h0;
        run(osd_pkg::OPC_GATE);
        chk({level_fault, priv_fault, cur_level}, 4'h0);
        $display("level test done");
        irq_id = 8'h5a;
        run(osd_pkg::OPC_WAIT);
        chk(fetch_halted, 1'b1);
        for (int k = 0; k < 5; k++) begin
            ev(evt[k][6:5], evt[k][4]);
            chk({useq_start, fetch_halted, proc_switch, gate_xfer, useq_id},
                {2'b10, evt[k][3], !evt[k][3], evt[k][2:0]});
            chk(cur_level, 2'h0);
        end
        run(osd_pkg::OPC_IRQ_ACK);
        chk({gw_en, gw_d}, {1'b1, 32'h5a});
        $display("event test done");
        conclude();
    end
endmodule : os_instruction_privilege_decoder_test
